// *** hdl/swp_link_top.sv ***
// Single-wire programming link: request detect, bit codec, command engine, clamp codes.
// Assumes LINE_I is a clean digital view of the output pin, synchronous to CORE_CLK_I.
`timescale 1ns/1ps
`include "swp_defs.svh"
module swp_link_top import swp_pkg::*; #(
   parameter logic [13:0] TX_PERIOD_TICKS = 14'(`SWP_TX_PERIOD_TICKS),
   parameter logic [13:0] REQ_LOW_TICKS = 14'(`SWP_REQ_LOW_TICKS),
   parameter logic [13:0] REQ_DLY_TICKS = 14'(`SWP_REQ_DLY_TICKS),
   parameter logic [13:0] RX_TMO_TICKS = 14'(`SWP_RX_TMO_TICKS),
   parameter logic [7:0] OP_STOP = 8'h01,
   parameter logic [7:0] OP_ECHO = 8'h02,
   parameter logic [7:0] OP_WRITE = 8'h03,
   parameter logic [7:0] OP_READ = 8'h04,
   parameter logic [7:0] OP_TEMP = 8'h05,
   parameter logic [7:0] OP_LOCK = 8'h06,
   parameter logic [7:0] OP_TEST_POS = 8'h07,
   parameter logic [7:0] OP_TEST_NEG = 8'h08,
   parameter logic LONG_LOW_IS_ONE = 1'b1
) (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic LINE_I,
   output logic LINE_O,
   output logic LINE_OE_O,
   input wire logic [9:0] TEMP_ADC_I,
   output logic ANALOG_EN_O,
   output logic COMM_MODE_O,
   output logic TEST_POS_O,
   output logic TEST_NEG_O,
   output logic [2:0] CLAMP_LOW_O,
   output logic [2:0] CLAMP_HIGH_O,
   output logic LOCKED_O,
   output logic PARITY_ERR_O
);
   localparam logic [13:0] TX_SHORT = 14'(32'(TX_PERIOD_TICKS) * `SWP_DUTY_SHORT_PCT / 100);
   localparam logic [13:0] TX_LONG = TX_PERIOD_TICKS - TX_SHORT;
   localparam logic [13:0] GAP_TICKS = 14'(`SWP_GAP_TICKS);

   logic [3:0] div_ff;
   logic tick;
   swp_main_st_t st_ff;
   logic [13:0] cnt_ff;
   logic is_wr_ff;
   logic [5:0] addr_ff;
   logic [1:0] send_cnt_ff;
   logic [7:0] send_b0_ff;
   logic [7:0] send_b1_ff;
   logic lock_ff;
   logic [3:0] sh_a_ff;
   logic [3:0] sh_b_ff;
   swp_rx_st_t rx_st_ff;
   logic line_q_ff;
   logic [13:0] lo_ff;
   logic [13:0] hi_ff;
   logic [7:0] rx_sh_ff;
   logic [3:0] rx_bit_ff;
   logic rx_stb_ff;
   logic [7:0] rx_byte_ff;
   logic rx_en;
   logic fall;
   logic rx_shift;
   logic rx_val;
   swp_tx_st_t tx_st_ff;
   logic [13:0] tcnt_ff;
   logic [7:0] tsh_ff;
   logic [3:0] tbit_ff;
   logic [13:0] low_len;
   logic bi_ready;
   logic bo_valid;
   logic bo_ready;
   logic [7:0] bo_data;
   logic bi_valid;
   swp_mem_req_t mreq;
   logic [4:0] mem_rdata;
   logic mem_perr;
   logic rd_pend_ff;
   logic test_neg_ff;

   // All protocol timing runs on this tick, so it scales with the oscillator
   assign tick = (div_ff == 4'(`SWP_OSC_DIV - 1));

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         div_ff <= 4'h0;
      end else if (tick) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   // Bit receiver: the low phase is compared with the high phase that follows
   assign rx_en = (st_ff == ST_RX_CMD) | (st_ff == ST_RX_ADDR) | (st_ff == ST_RX_DATA);
   assign fall = line_q_ff & !LINE_I;
   assign rx_shift = ((rx_st_ff == RX_HIGH) & (hi_ff >= lo_ff)) | ((rx_st_ff == RX_HIGH) & fall);
   // Short low decided once the high phase lasts as long as it; long low when the next edge comes first
   assign rx_val = (hi_ff >= lo_ff) ? !LONG_LOW_IS_ONE : LONG_LOW_IS_ONE;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         line_q_ff <= 1'b1;
      end else begin
         line_q_ff <= LINE_I;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_st_ff <= RX_WAIT;
         lo_ff <= 14'h0000;
         hi_ff <= 14'h0000;
      end else if (!rx_en) begin
         rx_st_ff <= RX_WAIT;
      end else begin
         case (rx_st_ff)
            RX_WAIT: begin
               // High after the request is simply waited out
               if (fall) begin
                  rx_st_ff <= RX_LOW;
                  lo_ff <= 14'h0000;
               end
            end
            RX_LOW: begin
               if (LINE_I) begin
                  rx_st_ff <= RX_HIGH;
                  hi_ff <= 14'h0000;
               end else if (lo_ff >= RX_TMO_TICKS) begin
                  rx_st_ff <= RX_WAIT;
               end else if (tick) begin
                  lo_ff <= lo_ff + 14'h0001;
               end
            end
            RX_HIGH: begin
               if (fall) begin
                  rx_st_ff <= RX_LOW;
                  lo_ff <= 14'h0000;
               end else if (hi_ff >= lo_ff) begin
                  rx_st_ff <= RX_WAIT;
               end else if (tick) begin
                  hi_ff <= hi_ff + 14'h0001;
               end
            end
            default: rx_st_ff <= RX_WAIT;
         endcase
      end
   end

   // Byte assembly, first bit is the MSB; a stalled bit drops the partial byte
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_sh_ff <= 8'h00;
         rx_bit_ff <= 4'h0;
         rx_stb_ff <= 1'b0;
         rx_byte_ff <= 8'h00;
      end else begin
         rx_stb_ff <= 1'b0;
         if (!rx_en | ((rx_st_ff == RX_LOW) & (lo_ff >= RX_TMO_TICKS))) begin
            rx_bit_ff <= 4'h0;
         end else if (rx_shift) begin
            rx_sh_ff <= {rx_sh_ff[6:0], rx_val};
            if (rx_bit_ff == `SWP_LAST_BIT) begin
               rx_bit_ff <= 4'h0;
               rx_stb_ff <= 1'b1;
               rx_byte_ff <= {rx_sh_ff[6:0], rx_val};
            end else begin
               rx_bit_ff <= rx_bit_ff + 4'h1;
            end
         end
      end
   end

   // Memory requests from the command engine
   always_comb begin
      mreq.addr = (st_ff == ST_RX_ADDR) ? rx_byte_ff[`SWP_ADDR_FIELD] : addr_ff;
      mreq.wdata = rx_byte_ff[`SWP_DATA_FIELD];
      mreq.re = (st_ff == ST_RX_ADDR) & rx_stb_ff & (rx_byte_ff[`SWP_ADDR_HI_FIELD] == 2'h0) & !is_wr_ff;
      mreq.we = (st_ff == ST_RX_DATA) & rx_stb_ff & (rx_byte_ff[`SWP_DATA_HI_FIELD] == 3'h0) & !lock_ff;
   end

   swp_cal_mem u_mem (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .req_i(mreq),
      .rdata_o(mem_rdata),
      .perr_o(mem_perr)
   );

   // Command engine
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_ff <= ST_NORMAL;
         cnt_ff <= 14'h0000;
         is_wr_ff <= 1'b0;
         addr_ff <= 6'h00;
         send_cnt_ff <= 2'h0;
         send_b0_ff <= 8'h00;
         send_b1_ff <= 8'h00;
         TEST_POS_O <= 1'b0;
         TEST_NEG_O <= 1'b0;
         test_neg_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_NORMAL: begin
               if (LINE_I) begin
                  cnt_ff <= 14'h0000;
               end else if (cnt_ff >= REQ_LOW_TICKS) begin
                  st_ff <= ST_ARMED;
               end else if (tick) begin
                  cnt_ff <= cnt_ff + 14'h0001;
               end
            end
            ST_ARMED: begin
               if (LINE_I) begin
                  st_ff <= ST_REQ_DLY;
                  cnt_ff <= 14'h0000;
               end
            end
            ST_REQ_DLY: begin
               if (!LINE_I) begin
                  st_ff <= ST_ARMED;
               end else if (cnt_ff >= REQ_DLY_TICKS) begin
                  st_ff <= ST_RX_CMD;
               end else if (tick) begin
                  cnt_ff <= cnt_ff + 14'h0001;
               end
            end
            ST_RX_CMD: begin
               if (rx_stb_ff) begin
                  case (rx_byte_ff)
                     OP_STOP: begin
                        st_ff <= ST_NORMAL;
                        cnt_ff <= 14'h0000;
                     end
                     OP_ECHO: begin
                        send_b0_ff <= `SWP_ECHO_BYTE;
                        send_cnt_ff <= 2'h1;
                        st_ff <= ST_SEND;
                     end
                     OP_WRITE: begin
                        is_wr_ff <= 1'b1;
                        st_ff <= ST_RX_ADDR;
                     end
                     OP_READ: begin
                        is_wr_ff <= 1'b0;
                        st_ff <= ST_RX_ADDR;
                     end
                     OP_TEMP: begin
                        send_b0_ff <= TEMP_ADC_I[`SWP_ADC_MSB_FIELD];
                        send_b1_ff <= {TEMP_ADC_I[`SWP_ADC_LSB_FIELD], 6'h00};
                        send_cnt_ff <= 2'h2;
                        st_ff <= ST_SEND;
                     end
                     OP_TEST_POS: begin
                        test_neg_ff <= 1'b0;
                        st_ff <= ST_TEST;
                     end
                     OP_TEST_NEG: begin
                        test_neg_ff <= 1'b1;
                        st_ff <= ST_TEST;
                     end
                     default: st_ff <= ST_RX_CMD;
                  endcase
               end
            end
            ST_RX_ADDR: begin
               if (rx_stb_ff) begin
                  addr_ff <= rx_byte_ff[`SWP_ADDR_FIELD];
                  // Out-of-range address drops the command silently
                  if (rx_byte_ff[`SWP_ADDR_HI_FIELD] != 2'h0) begin
                     st_ff <= ST_RX_CMD;
                  end else begin
                     st_ff <= is_wr_ff ? ST_RX_DATA : ST_MEM_RD;
                  end
               end
            end
            ST_RX_DATA: begin
               if (rx_stb_ff) begin
                  st_ff <= ST_RX_CMD;
               end
            end
            ST_MEM_RD: begin
               send_b0_ff <= {3'h0, mem_rdata};
               send_cnt_ff <= 2'h1;
               st_ff <= ST_SEND;
            end
            ST_SEND: begin
               if (bi_valid & bi_ready) begin
                  send_b0_ff <= send_b1_ff;
                  send_cnt_ff <= send_cnt_ff - 2'h1;
               end else if ((send_cnt_ff == 2'h0) & !bo_valid & (tx_st_ff == TX_IDLE)) begin
                  st_ff <= ST_RX_CMD;
               end
            end
            // Only a chip reset leaves the test routing
            // Routing follows the state, so it never overlaps communication mode
            ST_TEST: begin
               st_ff <= ST_TEST;
               TEST_POS_O <= !test_neg_ff;
               TEST_NEG_O <= test_neg_ff;
            end
            default: st_ff <= ST_NORMAL;
         endcase
      end
   end

   // Lock survives everything but reset; parity flag is sticky
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         lock_ff <= 1'b0;
         PARITY_ERR_O <= 1'b0;
         rd_pend_ff <= 1'b0;
      end else begin
         rd_pend_ff <= mreq.re;
         if ((st_ff == ST_RX_CMD) & rx_stb_ff & (rx_byte_ff == OP_LOCK)) begin
            lock_ff <= 1'b1;
         end
         if (rd_pend_ff & mem_perr) begin
            PARITY_ERR_O <= 1'b1;
         end
      end
   end

   // Shadow of the clamp locations, kept in step with writes
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         sh_a_ff <= 4'h0;
         sh_b_ff <= 4'h0;
      end else if (mreq.we) begin
         if (addr_ff == `SWP_ADDR_CLAMP_A) begin
            sh_a_ff <= mreq.wdata[`SWP_NIB_FIELD];
         end
         if (addr_ff == `SWP_ADDR_CLAMP_B) begin
            sh_b_ff <= mreq.wdata[`SWP_NIB_FIELD];
         end
      end
   end

   assign CLAMP_LOW_O = sh_a_ff[`SWP_CLAMP_LOW_FIELD];
   assign CLAMP_HIGH_O = {sh_b_ff[`SWP_CLAMP_HI_B_FIELD], sh_a_ff[`SWP_CLAMP_HI_A_BIT]};
   assign LOCKED_O = lock_ff;

   // Reply bytes pass a two-entry buffer; the engine stalls on bi_ready
   assign bi_valid = (st_ff == ST_SEND) & (send_cnt_ff != 2'h0);
   assign bo_ready = (tx_st_ff == TX_IDLE);

   swp_two_buf u_buf (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RESET_N_I),
      .in_valid_i(bi_valid),
      .in_ready_o(bi_ready),
      .in_data_i(send_b0_ff),
      .out_valid_o(bo_valid),
      .out_ready_i(bo_ready),
      .out_data_o(bo_data)
   );

   // Bit transmitter, MSB first, high gap before each byte
   assign low_len = (tsh_ff[7] == LONG_LOW_IS_ONE) ? TX_LONG : TX_SHORT;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         tx_st_ff <= TX_IDLE;
         tcnt_ff <= 14'h0000;
         tsh_ff <= 8'h00;
         tbit_ff <= 4'h0;
      end else begin
         case (tx_st_ff)
            TX_IDLE: begin
               if (bo_valid) begin
                  tsh_ff <= bo_data;
                  tbit_ff <= 4'h0;
                  tcnt_ff <= 14'h0000;
                  tx_st_ff <= TX_GAP;
               end
            end
            TX_GAP: begin
               if (tick) begin
                  if (tcnt_ff == GAP_TICKS - 14'h0001) begin
                     tcnt_ff <= 14'h0000;
                     tx_st_ff <= TX_LOW;
                  end else begin
                     tcnt_ff <= tcnt_ff + 14'h0001;
                  end
               end
            end
            TX_LOW: begin
               if (tick) begin
                  if (tcnt_ff == low_len - 14'h0001) begin
                     tcnt_ff <= 14'h0000;
                     tx_st_ff <= TX_HIGH;
                  end else begin
                     tcnt_ff <= tcnt_ff + 14'h0001;
                  end
               end
            end
            TX_HIGH: begin
               if (tick) begin
                  // Low plus high always spans exactly one period
                  if (tcnt_ff == TX_PERIOD_TICKS - low_len - 14'h0001) begin
                     tcnt_ff <= 14'h0000;
                     tsh_ff <= {tsh_ff[6:0], 1'b0};
                     tbit_ff <= tbit_ff + 4'h1;
                     tx_st_ff <= (tbit_ff == `SWP_LAST_BIT) ? TX_IDLE : TX_LOW;
                  end else begin
                     tcnt_ff <= tcnt_ff + 14'h0001;
                  end
               end
            end
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end

   // Pin ownership: driven through the whole reply, analog stage only outside communication mode
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         LINE_OE_O <= 1'b0;
         LINE_O <= 1'b1;
         ANALOG_EN_O <= 1'b1;
         COMM_MODE_O <= 1'b0;
      end else begin
         LINE_OE_O <= (st_ff == ST_SEND) | (tx_st_ff != TX_IDLE);
         LINE_O <= (tx_st_ff != TX_LOW);
         ANALOG_EN_O <= (st_ff == ST_NORMAL) | (st_ff == ST_ARMED) | (st_ff == ST_REQ_DLY) | (st_ff == ST_TEST);
         COMM_MODE_O <= rx_en | (st_ff == ST_MEM_RD) | (st_ff == ST_SEND);
      end
   end
endmodule

// *** hdl/swp_defs.svh ***
// Constants of the single-wire programming link: rates, times, fields, addresses.
// Assumes a 40 MHz core clock; all protocol times run on a 4 MHz tick taken from it.
`ifndef SWP_DEFS_SVH
`define SWP_DEFS_SVH
`define SWP_CLK_HZ 40000000
`define SWP_OSC_HZ 4000000
`define SWP_OSC_DIV (`SWP_CLK_HZ / `SWP_OSC_HZ)
`define SWP_TICKS_PER_US (`SWP_OSC_HZ / 1000000)
`define SWP_TX_PERIOD_US 510
`define SWP_TX_PERIOD_MAX_US 695
`define SWP_TX_PERIOD_TICKS (`SWP_TX_PERIOD_US * `SWP_TICKS_PER_US)
`define SWP_DUTY_SHORT_PCT 30
`define SWP_GAP_US 5
`define SWP_GAP_TICKS (`SWP_GAP_US * `SWP_TICKS_PER_US)
`define SWP_REQ_LOW_US 100
`define SWP_REQ_LOW_TICKS (`SWP_REQ_LOW_US * `SWP_TICKS_PER_US)
`define SWP_REQ_DLY_US 1000
`define SWP_REQ_DLY_TICKS (`SWP_REQ_DLY_US * `SWP_TICKS_PER_US)
`define SWP_RX_TMO_US 2500
`define SWP_RX_TMO_TICKS (`SWP_RX_TMO_US * `SWP_TICKS_PER_US)
`define SWP_ECHO_BYTE 8'hA5
`define SWP_ADDR_CLAMP_A 6'h13
`define SWP_ADDR_CLAMP_B 6'h17
`define SWP_ADDR_HI_FIELD 7:6
`define SWP_ADDR_FIELD 5:0
`define SWP_DATA_HI_FIELD 7:5
`define SWP_DATA_FIELD 4:0
`define SWP_NIB_FIELD 3:0
`define SWP_CLAMP_LOW_FIELD 2:0
`define SWP_CLAMP_HI_A_BIT 3
`define SWP_CLAMP_HI_B_FIELD 1:0
`define SWP_ADC_MSB_FIELD 9:2
`define SWP_ADC_LSB_FIELD 1:0
`define SWP_LAST_BIT 4'h7
`endif

// *** hdl/swp_pkg.sv ***
// Types shared by the single-wire programming link modules.
// Assumes swp_defs.svh supplies the numeric constants.
package swp_pkg;
   typedef enum logic [8:0] {
      ST_NORMAL = 9'h001,
      ST_ARMED = 9'h002,
      ST_REQ_DLY = 9'h004,
      ST_RX_CMD = 9'h008,
      ST_RX_ADDR = 9'h010,
      ST_RX_DATA = 9'h020,
      ST_MEM_RD = 9'h040,
      ST_SEND = 9'h080,
      ST_TEST = 9'h100
   } swp_main_st_t;
   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_GAP = 4'h2,
      TX_LOW = 4'h4,
      TX_HIGH = 4'h8
   } swp_tx_st_t;
   typedef enum logic [2:0] {
      RX_WAIT = 3'h1,
      RX_LOW = 3'h2,
      RX_HIGH = 3'h4
   } swp_rx_st_t;
   typedef struct packed {
      logic we;
      logic re;
      logic [5:0] addr;
      logic [4:0] wdata;
   } swp_mem_req_t;
endpackage

// *** hdl/swp_cal_mem.sv ***
// Calibration store: 64 words of four data bits plus parity, each kept three times.
// Assumes one request per cycle; read data and parity flag are registered.
`timescale 1ns/1ps
`include "swp_defs.svh"
module swp_cal_mem import swp_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire swp_mem_req_t req_i,
   output logic [4:0] rdata_o,
   output logic perr_o
);
   logic [4:0] copy_a [64];
   logic [4:0] copy_b [64];
   logic [4:0] copy_c [64];
   logic [4:0] voted;

   // Triple copies written together
   always_ff @(posedge clk_i) begin
      if (req_i.we) begin
         copy_a[req_i.addr] <= req_i.wdata;
         copy_b[req_i.addr] <= req_i.wdata;
         copy_c[req_i.addr] <= req_i.wdata;
      end
   end

   // Bitwise two-of-three; a single upset copy is outvoted
   assign voted = (copy_a[req_i.addr] & copy_b[req_i.addr]) | (copy_a[req_i.addr] & copy_c[req_i.addr])
                | (copy_b[req_i.addr] & copy_c[req_i.addr]);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 5'h00;
         perr_o <= 1'b0;
      end else if (req_i.re) begin
         rdata_o <= voted;
         perr_o <= ^voted;
      end
   end
endmodule

// *** hdl/swp_two_buf.sv ***
// Two-entry byte buffer with valid and ready on both sides.
// Assumes the drain side may stall for any time; in_ready_o then drops.
`timescale 1ns/1ps
module swp_two_buf (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [7:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [7:0] out_data_o
);
   logic [7:0] slot1_ff;
   logic [1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_ff != 2'h2);
   assign out_valid_o = (cnt_ff != 2'h0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 2'h0;
      end else if (push & !pop) begin
         cnt_ff <= cnt_ff + 2'h1;
      end else if (pop & !push) begin
         cnt_ff <= cnt_ff - 2'h1;
      end
   end

   // Head in out_data_o, second entry in slot1_ff
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_data_o <= 8'h00;
         slot1_ff <= 8'h00;
      end else begin
         if (pop) begin
            out_data_o <= (cnt_ff == 2'h2) ? slot1_ff : in_data_i;
         end else if (push & (cnt_ff == 2'h0)) begin
            out_data_o <= in_data_i;
         end
         if (push & ((cnt_ff == 2'h2) | ((cnt_ff == 2'h1) & !pop))) begin
            slot1_ff <= in_data_i;
         end
      end
   end
endmodule

// *** test/swp_link_chk.sv ***
// Port checker for swp_link_top.
// Sees only top ports; bound below.
`timescale 1ns/1ps
module swp_link_chk #(
   parameter logic [13:0] TX_PERIOD_TICKS = 14'h07F8
) (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic LINE_I,
   input wire logic LINE_O,
   input wire logic LINE_OE_O,
   input wire logic [9:0] TEMP_ADC_I,
   input wire logic ANALOG_EN_O,
   input wire logic COMM_MODE_O,
   input wire logic TEST_POS_O,
   input wire logic TEST_NEG_O,
   input wire logic [2:0] CLAMP_LOW_O,
   input wire logic [2:0] CLAMP_HIGH_O,
   input wire logic LOCKED_O,
   input wire logic PARITY_ERR_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   logic [15:0] low_ff;
   logic [15:0] nxt_low;
   // Wide enough for the long low at full period
   assign nxt_low = (LINE_OE_O && !LINE_O) ? low_ff + 16'h0001 : 16'h0000;
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         low_ff <= 16'h0000;
      end else begin
         low_ff <= nxt_low;
      end
   end
   AST_OE_COMM: assert property (LINE_OE_O |-> COMM_MODE_O && !ANALOG_EN_O) else $error("oe mode");
   AST_MODE_EXCL: assert property (COMM_MODE_O |-> !ANALOG_EN_O && !TEST_POS_O) else $error("mode");
   AST_LOCK_HOLD: assert property (LOCKED_O |=> LOCKED_O) else $error("lock");
   AST_CLAMP_FROZEN: assert property (LOCKED_O && $past(LOCKED_O) |-> $stable({CLAMP_LOW_O, CLAMP_HIGH_O}))
      else $error("clamp");
   AST_TEST_HOLD: assert property (TEST_POS_O || TEST_NEG_O |=> $stable({TEST_POS_O, TEST_NEG_O}))
      else $error("test left");
   AST_TEST_ANALOG: assert property (TEST_POS_O || TEST_NEG_O |-> ANALOG_EN_O && !LINE_OE_O) else $error("test");
   AST_TX_OPEN_HIGH: assert property ($rose(LINE_OE_O) |-> LINE_O [*8]) else $error("open low");
   AST_TX_LOW_LEN: assert property ($rose(LINE_O) && LINE_OE_O |-> low_ff == 16'(TX_PERIOD_TICKS * 3)
      || low_ff == 16'(TX_PERIOD_TICKS * 7)) else $error("low width");
   cover property ($rose(COMM_MODE_O));
   cover property ($rose(LOCKED_O));
   cover property ($rose(TEST_POS_O));
endmodule
bind swp_link_top swp_link_chk #(.TX_PERIOD_TICKS(TX_PERIOD_TICKS)) u_chk (.*);

// *** test/swp_prog_model.sv ***
// Programmer model on the shared pin.
// Assumes a pull-up; the device wins while it drives.
`timescale 1ns/1ps
module swp_prog_model (
   input wire logic clk_i,
   input wire logic dev_val_i,
   input wire logic dev_oe_i,
   output logic line_o
);
   logic drv_en = 1'b0;
   logic drv_val = 1'b1;
   assign line_o = dev_oe_i ? dev_val_i : (drv_en ? drv_val : 1'b1);
   task automatic hold(input logic v, input int n);
      drv_val <= v;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic request;
      drv_en <= 1'b1;
      hold(1'b0, 100);
      hold(1'b1, 200);
   endtask
   // Bit 1 is the long low, as in the default mapping
   task automatic send_byte(input logic [7:0] b, input int s);
      drv_en <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
         hold(1'b0, b[i] ? 7 * s : 3 * s);
         hold(1'b1, b[i] ? 3 * s : 7 * s);
      end
   endtask
   task automatic recv_byte(output logic [7:0] b, output int bad);
      int n;
      bad = 0;
      b = 8'h00;
      drv_en <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         n = 0;
         while (line_o && n < 2000) begin
            @(posedge clk_i);
            n++;
         end
         n = 0;
         while (!line_o && n < 2000) begin
            @(posedge clk_i);
            n++;
         end
         if (n == 0 || !line_o) begin
            bad = 99;
            return;
         end
         b = {b[6:0], n > 200};
         bad += (n != 120 && n != 280);
      end
   endtask
endmodule

// *** test/single_wire_pwm_programming_bench.sv ***
// Bench for swp_link_top, shortened times.
// Assumes the checker binds itself.
`timescale 1ns/1ps
module single_wire_pwm_programming_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] adc = 10'h2B5;
   logic line, lo, oe, an, cm, tp, tn, lk, pe;
   logic [2:0] cl, ch;
   int fail_count = 0;
   int n_tests = 0;
   always #12.5 clk = ~clk;
   swp_link_top #(.TX_PERIOD_TICKS(14'h0028), .REQ_LOW_TICKS(14'h0004), .REQ_DLY_TICKS(14'h0008),
      .RX_TMO_TICKS(14'h0040)) u_dut (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .LINE_I(line), .LINE_O(lo), .LINE_OE_O(oe), .TEMP_ADC_I(adc),
      .ANALOG_EN_O(an), .COMM_MODE_O(cm), .TEST_POS_O(tp), .TEST_NEG_O(tn), .CLAMP_LOW_O(cl),
      .CLAMP_HIGH_O(ch), .LOCKED_O(lk), .PARITY_ERR_O(pe));
   swp_prog_model u_prog (.clk_i(clk), .dev_val_i(lo), .dev_oe_i(oe), .line_o(line));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   // A trailing fall closes a long last bit; a long one also drops the stray bit
   task automatic tx(input logic [23:0] w, input int k, input bit stay);
      for (int i = k - 1; i >= 0; i--)
         u_prog.send_byte(w[8 * i +: 8], 20);
      u_prog.hold(1'b0, stay ? 700 : 1);
      u_prog.hold(1'b1, 10);
   endtask
   task automatic rx(input logic [7:0] exp, input bit last);
      logic [7:0] b;
      int bad;
      u_prog.recv_byte(b, bad);
      if (bad == 99) begin
         fail_count++;
         complete_run;
      end
      check("reply", {8'h00, b}, {8'h00, exp});
      check("widths", 16'(bad), 16'h0000);
      if (last) begin
         for (int i = 0; i < 600 && oe; i++) @(posedge clk);
         check("release", {15'h0, oe}, 16'h0000);
      end
   endtask
   task automatic sc_entry;
      check("reset", {3'h0, oe, an, cm, tp, tn, lk, pe, cl, ch}, 16'h0800);
      u_prog.request();
      check("mode", {14'h0, cm, an}, 16'h0002);
      check("quiet", {15'h0, oe}, 16'h0000);
      tx(24'h000002, 1, 1'b0);
      rx(8'hA5, 1'b1);
   endtask
   task automatic sc_mem;
      tx(24'h031305, 3, 1'b1);
      tx(24'h031711, 3, 1'b1);
      tx(24'h031327, 3, 1'b1);
      check("clamps", {10'h0, cl, ch}, 16'h002A);
      tx(24'h000413, 2, 1'b0);
      rx(8'h05, 1'b1);
      check("parity", {15'h0, pe}, 16'h0000);
      tx(24'h032101, 3, 1'b1);
      tx(24'h000421, 2, 1'b0);
      rx(8'h01, 1'b1);
      check("parity", {15'h0, pe}, 16'h0001);
      tx(24'h000005, 1, 1'b0);
      rx(8'hAD, 1'b0);
      rx(8'h40, 1'b1);
   endtask
   task automatic sc_lock;
      tx(24'h000006, 1, 1'b1);
      tx(24'h031303, 3, 1'b1);
      check("locked", {9'h0, lk, cl, ch}, 16'h006A);
      tx(24'h000001, 1, 1'b0);
      check("stopped", {14'h0, cm, an}, 16'h0001);
   endtask
   task automatic sc_test;
      u_prog.request();
      tx(24'h000007, 1, 1'b0);
      u_prog.request();
      tx(24'h000008, 1, 1'b0);
      check("test", {12'h0, tp, tn, an, cm}, 16'h000A);
      do_reset;
      check("test off", {15'h0, tp}, 16'h0000);
      u_prog.request();
      tx(24'h000008, 1, 1'b0);
      check("test neg", {12'h0, tp, tn, an, cm}, 16'h0006);
   endtask
   initial begin
      do_reset;
      sc_entry;
      sc_mem;
      sc_lock;
      sc_test;
      complete_run;
   end
endmodule
